// ---- verilog/spt_timer.sv ----
// Purpose: 16-bit period timer with control, period, count, status and mask registers
// Assumes: ref_clk 250 MHz stands for the oscillator; pins are asynchronous
// Notes:   Function
// Function
// RULE1 - Run bit starts and stops counter
// RULE2 - Idle-stop bit halts timer in Idle
// RULE3 - Source bit picks half-rate clock or extended
// RULE4 - Extended select: RC, pin, secondary; 11 reserved
// RULE5 - Gate bit gates internal clock only
// RULE6 - Sync bit aligns external clock only
// RULE7 - Unimplemented control bits read zero
// RULE8 - Prescale field divides 1, 8, 64, 256
// RULE9 - Software loads the period register
// RULE10 - Period match clears counter, sets flag
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module spt_timer
	import spt_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              idleMode,
	input  wire spt_pins_t         extPins,
	output logic                   timerIrq
);

	if (ADDR_W < 5) begin : gChk
		$error("spt_timer: ADDR_W must be at least 5");
	end

	// ************************************************************
	// Pin synchronisers and edge detection
	// ************************************************************
	spt_pins_t pinMeta, pinSync, pinPrev;

	for (genvar i = 0; i < 4; i++) begin : gSync
		always_ff @(posedge ref_clk or posedge sys_rst) begin
			if (sys_rst) begin
				pinMeta[i] <= 1'b0;
				pinSync[i] <= 1'b0;
				pinPrev[i] <= 1'b0;
			end else begin
				pinMeta[i] <= extPins[i];
				pinSync[i] <= pinMeta[i];
				pinPrev[i] <= pinSync[i];
			end
		end
	end

	// ************************************************************
	// Registers and bus state
	// ************************************************************
	spt_ctrl_t         ctrl, next_ctrl;
	logic [15:0]       period, next_period;
	logic [15:0]       count, next_count;
	logic [STAT_W-1:0] status, next_status;
	logic [STAT_W-1:0] mask, next_mask;
	logic [STAT_W-1:0] statusSet;
	logic              awHeld, next_awHeld, wHeld, next_wHeld;
	logic [ADDR_W-1:0] awAddr, next_awAddr, wAddr;
	logic [31:0]       wData, next_wData, wDataEff;
	logic [3:0]        wStrb, next_wStrb, wStrbEff;
	logic              next_bvalid, next_rvalid;
	logic [1:0]        next_bresp, next_rresp;
	logic [31:0]       next_rdata;
	logic              doWrite, doRead, ctrlWrite;

	// Merge a 16-bit register with the low two byte lanes
	function automatic logic [15:0] sptMerge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0]) begin
			r[7:0] = d[7:0];
		end
		if (s[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction : sptMerge

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign doWrite  = (awHeld || s_axi_awvalid) && (wHeld || s_axi_wvalid) && !s_axi_bvalid;
	assign doRead   = s_axi_arvalid && s_axi_arready;
	assign wAddr    = awHeld ? awAddr : s_axi_awaddr;
	assign wDataEff = wHeld ? wData : s_axi_wdata;
	assign wStrbEff = wHeld ? wStrb : s_axi_wstrb;
	assign ctrlWrite = doWrite && (wAddr == ADDR_W'(ADDR_CONTROL));

	// Address and data are caught in either order, then written together
	always_comb begin
		next_awHeld = awHeld;
		next_wHeld  = wHeld;
		next_awAddr = awAddr;
		next_wData  = wData;
		next_wStrb  = wStrb;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp  = s_axi_bresp;
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rresp  = s_axi_rresp;
		next_rdata  = s_axi_rdata;
		next_ctrl   = ctrl;
		next_period = period;
		next_mask   = mask;
		next_status = status | statusSet;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = RESP_OKAY;
			case (wAddr)
				ADDR_W'(ADDR_CONTROL): next_ctrl = spt_ctrl_t'(
					sptMerge(ctrl, wDataEff, wStrbEff) & CONTROL_IMPL); // RULE7
				ADDR_W'(ADDR_PERIOD):  next_period = sptMerge(period, wDataEff, wStrbEff); // RULE9
				ADDR_W'(ADDR_COUNT):   ;
				ADDR_W'(ADDR_STATUS): begin
					// Write one to clear; a same-cycle event still sets
					if (wStrbEff[0]) begin
						next_status = (status & ~wDataEff[STAT_W-1:0]) | statusSet;
					end
				end
				ADDR_W'(ADDR_MASK): begin
					if (wStrbEff[0]) begin
						next_mask = wDataEff[STAT_W-1:0];
					end
				end
				default: next_bresp = RESP_SLVERR;
			endcase
		end
		if (doRead) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			case (s_axi_araddr)
				ADDR_W'(ADDR_CONTROL): next_rdata = {16'h0000, ctrl}; // RULE7
				ADDR_W'(ADDR_PERIOD):  next_rdata = {16'h0000, period};
				ADDR_W'(ADDR_COUNT):   next_rdata = {16'h0000, count};
				ADDR_W'(ADDR_STATUS):  next_rdata = {{(32-STAT_W){1'b0}}, status};
				ADDR_W'(ADDR_MASK):    next_rdata = {{(32-STAT_W){1'b0}}, mask};
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			awHeld       <= 1'b0;
			wHeld        <= 1'b0;
			awAddr       <= '0;
			wData        <= 32'h0000_0000;
			wStrb        <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= RESP_OKAY;
			s_axi_rdata  <= 32'h0000_0000;
			ctrl         <= spt_ctrl_t'(CONTROL_RESET);
			period       <= PERIOD_RESET;
			mask         <= MASK_RESET;
			status       <= STATUS_RESET;
		end else begin
			awHeld       <= next_awHeld;
			wHeld        <= next_wHeld;
			awAddr       <= next_awAddr;
			wData        <= next_wData;
			wStrb        <= next_wStrb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp  <= next_rresp;
			s_axi_rdata  <= next_rdata;
			ctrl         <= next_ctrl;
			period       <= next_period;
			mask         <= next_mask;
			status       <= next_status;
		end
	end

	assign timerIrq = |(status & mask);

	// ************************************************************
	// Clock source selection and counting
	// ************************************************************
	logic halfTick, extLevel, extPrev, extEdge, extPend, next_extPend;
	logic srcTick, psTick, counterRun, gatedMode, gateFall;

	// Half-rate internal clock enable
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			halfTick <= 1'b0;
		end else begin
			halfTick <= !halfTick;
		end
	end

	// Extended source mux; the reserved code yields no clock
	always_comb begin
		case (ctrl.extendedClockSelect) // RULE4
			ECS_LOW_POWER_RC_OSC:      begin extLevel = pinSync.lowPowerRcOsc; extPrev = pinPrev.lowPowerRcOsc; end
			ECS_EXT_PIN:   begin extLevel = pinSync.extClockPin;   extPrev = pinPrev.extClockPin;   end
			ECS_SECONDARY: begin extLevel = pinSync.secondaryOsc;  extPrev = pinPrev.secondaryOsc;  end
			default:       begin extLevel = 1'b0;                  extPrev = 1'b0;                  end
		endcase
	end
	assign extEdge = extLevel && !extPrev;

	assign counterRun = ctrl.timerRun && !(idleMode && ctrl.idleStopSelect); // RULE1 RULE2
	assign gatedMode  = !ctrl.clockSourceSelect && ctrl.gatedAccumEnable; // RULE5
	assign gateFall   = gatedMode && counterRun && pinPrev.gatePin && !pinSync.gatePin;

	// Synchronised mode holds an edge until the next internal tick
	always_comb begin
		next_extPend = (extPend || extEdge) && !halfTick;
		if (!ctrl.extClockSync || !ctrl.clockSourceSelect) begin
			next_extPend = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			extPend <= 1'b0;
		end else begin
			extPend <= next_extPend;
		end
	end

	// Source tick: internal half-rate, gated or not, else an external edge
	always_comb begin
		if (!ctrl.clockSourceSelect) begin // RULE3
			srcTick = halfTick && (!ctrl.gatedAccumEnable || pinSync.gatePin); // RULE5
		end else if (ctrl.extClockSync) begin
			srcTick = (extPend || extEdge) && halfTick; // RULE6
		end else begin
			srcTick = extEdge;
		end
	end

	spt_prescaler #(
		.CNT_W          (8)
	) uPrescaler (
		.ref_clk        (ref_clk),
		.sys_rst        (sys_rst),
		.clear          (ctrlWrite || !counterRun),
		.inTick         (srcTick && counterRun),
		.prescaleSelect (ctrl.prescaleSelect),
		.outTick        (psTick)
	);

	// Counter wraps to zero on the tick where the count matches the period
	always_comb begin
		next_count = count;
		statusSet  = '0;
		if (psTick && counterRun) begin
			if (count == period) begin // RULE10
				next_count = 16'h0000;
				statusSet[STAT_PERIOD] = 1'b1;
			end else begin
				next_count = count + 16'h0001; // RULE1
			end
		end
		statusSet[STAT_GATE] = gateFall;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= COUNT_RESET;
		end else begin
			count <= next_count;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	sequence seqMatch;
		psTick && counterRun && count == period;
	endsequence

	AST_STOPPED: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
		!ctrl.timerRun |=> $stable(count))
		else $error("Counter moved while stopped");
	AST_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE2
		(idleMode && ctrl.idleStopSelect) |-> !psTick ##1 $stable(count))
		else $error("Counter moved in idle with idle-stop set");
	AST_INTERNAL: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE3
		(!ctrl.clockSourceSelect && srcTick) |-> halfTick && !$past(halfTick))
		else $error("Internal source not at half rate");
	AST_RESERVED_SRC: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE4
		(ctrl.clockSourceSelect && ctrl.extendedClockSelect == 2'h3) |-> !srcTick)
		else $error("Reserved source produced a tick");
	AST_GATE_LOW: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE5
		(gatedMode && !pinSync.gatePin) |-> !srcTick)
		else $error("Gated count advanced with gate low");
	AST_SYNC_ALIGN: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE6
		(ctrl.clockSourceSelect && ctrl.extClockSync && srcTick) |-> halfTick)
		else $error("Synchronised tick off the internal clock");
	AST_RSV_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE7
		(s_axi_rvalid && $rose(s_axi_rvalid) && $past(s_axi_araddr) == ADDR_W'(ADDR_CONTROL))
			|-> (s_axi_rdata[31:0] & ~{16'h0000, CONTROL_IMPL}) == 32'h0000_0000)
		else $error("Unimplemented control bits read nonzero");
	AST_WRAP: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE10
		seqMatch |=> count == 16'h0000 && status[STAT_PERIOD])
		else $error("Period match did not wrap and flag");
	AST_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE10
		(seqMatch and mask[STAT_PERIOD]) |=> timerIrq)
		else $error("Unmasked period flag did not raise interrupt");

endmodule : spt_timer

// ---- shared/spt_pkg.sv ----
// Purpose: Shared constants and types for the 16-bit period timer
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes:   Control word layout mirrors the register bit positions
package spt_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0]  ADDR_CONTROL = 8'h00;
	localparam logic [7:0]  ADDR_PERIOD  = 8'h04;
	localparam logic [7:0]  ADDR_COUNT   = 8'h08;
	localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
	localparam logic [7:0]  ADDR_MASK    = 8'h10;

	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_IMPL  = 16'ha376; // Writable bit positions
	localparam logic [15:0] PERIOD_RESET  = 16'hffff;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;

	// Status and mask bit positions
	localparam int          STAT_W       = 2;
	localparam int          STAT_PERIOD  = 0;
	localparam int          STAT_GATE    = 1;
	localparam logic [1:0]  STATUS_RESET = 2'h0;
	localparam logic [1:0]  MASK_RESET   = 2'h0;

	// Extended clock select codes
	localparam logic [1:0]  ECS_SECONDARY = 2'h0;
	localparam logic [1:0]  ECS_EXT_PIN   = 2'h1;
	localparam logic [1:0]  ECS_LOW_POWER_RC_OSC      = 2'h2;

	// Prescaler terminal counts (ratio minus one)
	localparam logic [7:0]  PS_LIMIT_1   = 8'h00;
	localparam logic [7:0]  PS_LIMIT_8   = 8'h07;
	localparam logic [7:0]  PS_LIMIT_64  = 8'h3f;
	localparam logic [7:0]  PS_LIMIT_256 = 8'hff;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic       timerRun;
		logic       rsv14;
		logic       idleStopSelect;
		logic [2:0] rsv12;
		logic [1:0] extendedClockSelect;
		logic       rsv7;
		logic       gatedAccumEnable;
		logic [1:0] prescaleSelect;
		logic       rsv3;
		logic       extClockSync;
		logic       clockSourceSelect;
		logic       rsv0;
	} spt_ctrl_t;

	// Asynchronous inputs, one bit per pin
	typedef struct packed {
		logic gatePin;
		logic lowPowerRcOsc;
		logic extClockPin;
		logic secondaryOsc;
	} spt_pins_t;

endpackage : spt_pkg

// ---- verilog/spt_prescaler.sv ----
// Purpose: Input clock prescaler, one output tick per 1, 8, 64 or 256 input ticks
// Assumes: inTick is a one-cycle enable on ref_clk
// Notes:   clear restarts the division so a new ratio starts cleanly
`timescale 1ns/1ps
module spt_prescaler
	import spt_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       clear,
	input  wire logic       inTick,
	input  wire logic [1:0] prescaleSelect,
	output logic            outTick
);

	// ************************************************************
	// Division counter
	// ************************************************************
	if (CNT_W < 8) begin : gChk
		$error("spt_prescaler: CNT_W must be at least 8");
	end

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] limit;

	// Ratio decode
	always_comb begin
		case (prescaleSelect)
			2'h3:    limit = CNT_W'(PS_LIMIT_256);
			2'h2:    limit = CNT_W'(PS_LIMIT_64);
			2'h1:    limit = CNT_W'(PS_LIMIT_8);
			default: limit = CNT_W'(PS_LIMIT_1);
		endcase
	end

	assign outTick = inTick && (cnt >= limit); // RULE8

	// Wrap on the terminal count; >= guards a ratio lowered mid-count
	always_comb begin
		next_cnt = cnt;
		if (clear) begin
			next_cnt = '0;
		end else if (outTick) begin
			next_cnt = '0;
		end else if (inTick) begin
			next_cnt = cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	// A ratio change always comes with a clear, so the wrap point is exact
	AST_PS_EIGHT: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE8
		(outTick && prescaleSelect == 2'h1) |-> cnt == CNT_W'(7) ##1 cnt == CNT_W'(0))
		else $error("Prescaler 1:8 wrapped at the wrong count");

endmodule : spt_prescaler

// ---- verification/spt_timer_tb.sv ----
// Purpose: Self-checking bench for the 16-bit period timer over AXI4-Lite
// Assumes: Bus answers within a few cycles; pins change slowly against ref_clk
// Notes:   Count windows allow slack because reads take a few cycles each
`timescale 1ns/1ps
module spt_timer_tb
	import spt_pkg::*;
;

	// ************************************************************
	// Signals and design
	// ************************************************************
	logic        ref_clk;
	logic        sys_rst;
	logic [7:0]  awAddr;
	logic        awValid;
	logic        awReady;
	logic [31:0] wData;
	logic        wValid;
	logic        wReady;
	logic [1:0]  bResp;
	logic        bValid;
	logic        bReady;
	logic [7:0]  arAddr;
	logic        arValid;
	logic        arReady;
	logic [31:0] rData;
	logic [1:0]  rResp;
	logic        rValid;
	logic        rReady;
	logic        idleMode;
	spt_pins_t   pins;
	logic        timerIrq;
	int          errTotal;
	int          testsRun;
	int          cycles;

	// Compare and count; an unknown never passes
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin errTotal++; \
	$display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); end end

	spt_timer i_spt_timer (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.s_axi_awaddr (awAddr),
		.s_axi_awvalid(awValid),
		.s_axi_awready(awReady),
		.s_axi_wdata  (wData),
		.s_axi_wstrb  (4'hf),
		.s_axi_wvalid (wValid),
		.s_axi_wready (wReady),
		.s_axi_bresp  (bResp),
		.s_axi_bvalid (bValid),
		.s_axi_bready (bReady),
		.s_axi_araddr (arAddr),
		.s_axi_arvalid(arValid),
		.s_axi_arready(arReady),
		.s_axi_rdata  (rData),
		.s_axi_rresp  (rResp),
		.s_axi_rvalid (rValid),
		.s_axi_rready (rReady),
		.idleMode     (idleMode),
		.extPins      (pins),
		.timerIrq     (timerIrq)
	);

	// ************************************************************
	// Clock, timeout and verdict
	// ************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Ceiling well above the longest prescale window plus bus traffic
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			errTotal++;
			giveVerdict();
		end
	end

	task automatic giveVerdict();
		$display("comparisons %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : giveVerdict

	// ************************************************************
	// Bus tasks
	// ************************************************************
	// Both channels offered together, each released once taken
	task automatic wr(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] expResp);
		logic [1:0] resp;
		@(posedge ref_clk);
		awAddr  <= addr;
		wData   <= data;
		awValid <= 1'b1;
		wValid  <= 1'b1;
		bReady  <= 1'b1;
		resp = 2'h3;
		for (int n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (awValid && awReady)
				awValid <= 1'b0;
			if (wValid && wReady)
				wValid <= 1'b0;
			if (bValid) begin
				resp = bResp;
				bReady <= 1'b0;
				break;
			end
		end
		`CHK(resp, expResp)
	endtask : wr

	task automatic rd(input logic [7:0] addr, output logic [31:0] data, input logic [1:0] expResp);
		logic [1:0] resp;
		@(posedge ref_clk);
		arAddr  <= addr;
		arValid <= 1'b1;
		rReady  <= 1'b1;
		resp = 2'h3;
		data = 32'hxxxxxxxx;
		for (int n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (arValid && arReady)
				arValid <= 1'b0;
			if (rValid) begin
				resp = rResp;
				data = rData;
				rReady <= 1'b0;
				break;
			end
		end
		`CHK(resp, expResp)
	endtask : rd

	// Count advance over a fixed window of clock cycles
	task automatic countDiff(input int span, output logic [15:0] d);
		logic [31:0] a;
		logic [31:0] b;
		rd(ADDR_COUNT, a, RESP_OKAY);
		repeat (span) @(posedge ref_clk);
		rd(ADDR_COUNT, b, RESP_OKAY);
		d = b[15:0] - a[15:0];
	endtask : countDiff

	// Count advance over four slow pulses on one pin; slow so both sync modes see each edge
	task automatic extDiff(input int idx, output logic [15:0] d);
		logic [31:0] a;
		logic [31:0] b;
		rd(ADDR_COUNT, a, RESP_OKAY);
		repeat (4) begin
			@(posedge ref_clk);
			pins[idx] <= 1'b1;
			repeat (6) @(posedge ref_clk);
			pins[idx] <= 1'b0;
			repeat (6) @(posedge ref_clk);
		end
		repeat (8) @(posedge ref_clk);
		rd(ADDR_COUNT, b, RESP_OKAY);
		d = b[15:0] - a[15:0];
	endtask : extDiff

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		logic [31:0] rv;
		logic [31:0] rw;
		logic [15:0] d;
		logic [7:0]  rstAddr [5];
		logic [31:0] rstVal [5];
		int          ratio;
		rstAddr = '{ADDR_CONTROL, ADDR_PERIOD, ADDR_COUNT, ADDR_STATUS, ADDR_MASK};
		rstVal = '{32'h0, {16'h0, PERIOD_RESET}, 32'h0, 32'h0, 32'h0};
		sys_rst = 1'b1;
		awAddr = 8'h00;
		awValid = 1'b0;
		wData = 32'h0;
		wValid = 1'b0;
		bReady = 1'b0;
		arAddr = 8'h00;
		arValid = 1'b0;
		rReady = 1'b0;
		idleMode = 1'b0;
		pins = '0;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(rstAddr[i], rv, RESP_OKAY);
			`CHK(rv, rstVal[i])
		end
		wr(ADDR_CONTROL, 32'hffffffff, RESP_OKAY);
		rd(ADDR_CONTROL, rv, RESP_OKAY);
		`CHK(rv, 32'h0000a376)
		wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
		wr(8'h14, 32'h1, RESP_SLVERR);
		rd(8'h14, rv, RESP_SLVERR);
		`CHK(rv, 32'h0)
		$display("test registers done");
		// Internal clock at half rate through each prescale ratio
		for (int c = 0; c < 4; c++) begin
			ratio = (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 64 : 256;
			wr(ADDR_CONTROL, 32'h8000 | 32'(c << 4), RESP_OKAY);
			countDiff(16 * ratio, d);
			`CHK((d >= 16'h7) && (d <= 16'ha), 1'b1)
		end
		wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
		countDiff(64, d);
		`CHK(d, 16'h0)
		rd(ADDR_COUNT, rv, RESP_OKAY);
		wr(ADDR_COUNT, 32'h1234, RESP_OKAY);
		rd(ADDR_COUNT, rw, RESP_OKAY);
		`CHK(rw, rv)
		$display("test prescale and run done");
		// Idle stop only when the idle-stop bit is set
		idleMode <= 1'b1;
		wr(ADDR_CONTROL, 32'ha000, RESP_OKAY);
		countDiff(64, d);
		`CHK(d, 16'h0)
		wr(ADDR_CONTROL, 32'h8000, RESP_OKAY);
		countDiff(64, d);
		`CHK((d >= 16'h1f) && (d <= 16'h24), 1'b1)
		idleMode <= 1'b0;
		$display("test idle done");
		// Gated accumulation, gate fall event and its interrupt
		wr(ADDR_CONTROL, 32'h8040, RESP_OKAY);
		countDiff(64, d);
		`CHK(d, 16'h0)
		pins[3] <= 1'b1;
		repeat (8) @(posedge ref_clk);
		countDiff(64, d);
		`CHK((d >= 16'h1f) && (d <= 16'h24), 1'b1)
		wr(ADDR_MASK, 32'h2, RESP_OKAY);
		pins[3] <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rd(ADDR_STATUS, rv, RESP_OKAY);
		`CHK(rv, 32'h2)
		`CHK(timerIrq, 1'b1)
		wr(ADDR_MASK, 32'h0, RESP_OKAY);
		`CHK(timerIrq, 1'b0)
		wr(ADDR_STATUS, 32'h2, RESP_OKAY);
		rd(ADDR_STATUS, rv, RESP_OKAY);
		`CHK(rv, 32'h0)
		$display("test gate done");
		// Each extended source counts only its own pin; sync on odd codes
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_CONTROL, 32'h8042 | 32'(c << 8) | 32'((c & 1) << 2), RESP_OKAY);
			extDiff((c + 1) % 4, d);
			`CHK(d, 16'h0)
			extDiff(c, d);
			`CHK(d, (c == 3) ? 16'h0 : 16'h4)
		end
		wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
		wr(ADDR_STATUS, 32'h3, RESP_OKAY);
		$display("test external sources done");
		// Reset with the timer stopped zeroes the count and restores the period to PERIOD_RESET
		sys_rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(ADDR_COUNT, rv, RESP_OKAY);
		`CHK(rv, {16'h0000, COUNT_RESET})
		rd(ADDR_PERIOD, rv, RESP_OKAY);
		`CHK(rv, {16'h0000, PERIOD_RESET})
		// Short period wraps the count and raises the period flag
		wr(ADDR_PERIOD, 32'h3, RESP_OKAY);
		wr(ADDR_MASK, 32'h1, RESP_OKAY);
		wr(ADDR_CONTROL, 32'h8000, RESP_OKAY);
		for (int n = 0; n < 200; n++) begin
			@(posedge ref_clk);
			if (timerIrq === 1'b1)
				break;
		end
		`CHK(timerIrq, 1'b1)
		rd(ADDR_COUNT, rv, RESP_OKAY);
		`CHK(rv <= 32'h3, 1'b1)
		wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
		rd(ADDR_STATUS, rv, RESP_OKAY);
		`CHK(rv[0], 1'b1)
		wr(ADDR_STATUS, 32'h1, RESP_OKAY);
		rd(ADDR_STATUS, rv, RESP_OKAY);
		`CHK(rv, 32'h0)
		`CHK(timerIrq, 1'b0)
		$display("test period done");
		giveVerdict();
	end

endmodule : spt_timer_tb
